// *** wsw_top.sv ***
// Decided for this implementation: the register offsets and register access over APB.
module wsw_top import wsw_pkg::*; #(
	parameter logic [7:0] WAKE_SRC = 8'h7F
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] config_word,
	input wire logic ext_reset_pin_n,
	input wire logic crystal_startup_busy,
	input wire logic osc_fail,
	input wire logic [7:0] irq_event,
	output wsw_core_t core,
	output logic [15:0] vector_addr
);
	// ********************
	// state
	// ********************
	typedef struct packed {
		wsw_state_t st;
		logic [11:0] div;
		logic slow_tick;
		logic [4:0] wdtctl;
		logic [7:0] option;
		logic pd;
		logic to;
		logic global_irq_enable;
		logic [7:0] irq_en;
		logic [7:0] irq_flag;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		wsw_core_t core;
		logic [15:0] vaddr;
	} wsw_top_t;

	wsw_top_t s_r, s_nxt;
	logic fuse_en, wdt_on, xtal, wdt_clr, tmo, pending;
	logic wr, rd_setup, cmd_clear, cmd_sleep, cmd_return;
	logic [7:0] ev;

	// ********************
	// watchdog enable and clear
	// ********************
	assign fuse_en = config_word[CFG_FUSE_BIT];
	assign wdt_on = fuse_en | s_r.wdtctl[0];
	assign xtal = config_word[2:0] < FOSC_FIRST_NON_XTAL;
	assign wr = psel & penable & s_r.pready & pwrite;
	assign rd_setup = psel & ~penable;
	assign cmd_clear = wr && paddr == OFS_CMD && pwdata[CMD_CLEAR_BIT];
	assign cmd_sleep = wr && paddr == OFS_CMD && pwdata[CMD_SLEEP_BIT];
	assign cmd_return = wr && paddr == OFS_CMD && pwdata[CMD_RETURN_BIT];
	assign pending = |(s_r.irq_en & s_r.irq_flag);
	// no clock reaches other sources while asleep, so they cannot flag
	assign ev = (s_r.st == WSW_SLEEP) ? (irq_event & WAKE_SRC) : irq_event;

	// the start-up timer borrows the ripple counter, so the count restarts
	// only once that timer lets go
	assign wdt_clr = !wdt_on || cmd_clear || osc_fail
		|| (crystal_startup_busy && xtal)
		|| (s_r.st == WSW_SLEEP && pending)
		|| (cmd_sleep && s_r.st == WSW_RUN && !pending)
		|| !ext_reset_pin_n || s_r.core.reset || s_r.st == WSW_WAKE;

	wsw_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.tick(s_r.slow_tick & wdt_on),
		.clr(wdt_clr),
		.period_sel(s_r.wdtctl[4:1]),
		.use_post(s_r.option[OPT_OWNER_BIT]),
		.post_rate(s_r.option[2:0]),
		.tmo(tmo)
	);

	// ********************
	// next state
	// ********************
	always_comb begin
		s_nxt = s_r;
		s_nxt.core.reset = 1'b0;
		s_nxt.core.wake = 1'b0;
		s_nxt.core.vector = 1'b0;
		s_nxt.core.prefetch = 1'b0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		// slow oscillator modelled as a one-cycle enable
		if (s_r.div == 12'(SLOW_DIV - 1)) begin
			s_nxt.div = 12'h000;
			s_nxt.slow_tick = 1'b1;
		end else begin
			s_nxt.div = s_r.div + 12'h001;
			s_nxt.slow_tick = 1'b0;
		end
		// register access, answered in the first access cycle
		if (rd_setup) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h00000000;
			case (paddr)
				OFS_WDTCTL: s_nxt.prdata[4:0] = s_r.wdtctl;
				OFS_OPTION: s_nxt.prdata[7:0] = s_r.option;
				OFS_CONFIG: s_nxt.prdata[7:0] = config_word;
				OFS_CMD: s_nxt.prdata = 32'h00000000;
				OFS_STATUS: s_nxt.prdata[3:0] = {s_r.core.asleep, s_r.global_irq_enable, s_r.to, s_r.pd};
				OFS_IRQ_EN: s_nxt.prdata[7:0] = s_r.irq_en;
				OFS_IRQ_FLAG: s_nxt.prdata[7:0] = s_r.irq_flag;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (paddr)
				OFS_WDTCTL: s_nxt.wdtctl = pwdata[4:0];
				OFS_OPTION: s_nxt.option = pwdata[7:0];
				OFS_STATUS: s_nxt.global_irq_enable = pwdata[ST_GIE_BIT];
				OFS_IRQ_EN: s_nxt.irq_en = pwdata[7:0];
				OFS_IRQ_FLAG: s_nxt.irq_flag = s_r.irq_flag & ~pwdata[7:0];
				default: s_nxt.pslverr = 1'b0;
			endcase
		end
		if (cmd_return) begin
			s_nxt.global_irq_enable = 1'b1;
		end
		// a new event wins over a clear in the same cycle
		s_nxt.irq_flag = s_nxt.irq_flag | ev;
		case (s_r.st)
			WSW_RUN: begin
				if (cmd_sleep && !pending) begin
					s_nxt.st = WSW_SLEEP;
					s_nxt.pd = 1'b0;
					s_nxt.to = 1'b1;
					s_nxt.core.osc_off = 1'b1;
					s_nxt.core.io_hold = 1'b1;
					s_nxt.core.asleep = 1'b1;
					s_nxt.core.prefetch = 1'b1;
				end
			end
			WSW_SLEEP: begin
				if (tmo) begin
					s_nxt.st = WSW_WAKE;
					s_nxt.to = 1'b0;
				end else if (pending) begin
					// woken regardless of global enable
					s_nxt.st = WSW_WAKE;
				end
			end
			WSW_WAKE: begin
				s_nxt.st = WSW_RUN;
				s_nxt.core.wake = 1'b1;
				s_nxt.core.osc_off = 1'b0;
				s_nxt.core.io_hold = 1'b0;
				s_nxt.core.asleep = 1'b0;
				if (s_r.global_irq_enable && pending) begin
					s_nxt.core.vector = 1'b1;
					s_nxt.vaddr = IRQ_VECTOR;
					s_nxt.global_irq_enable = 1'b0;
				end
			end
			default: s_nxt.st = WSW_RUN;
		endcase
		// awake overflow resets the core; the reset pin is only an input
		if (tmo && s_r.st == WSW_RUN) begin
			s_nxt.core.reset = 1'b1;
			s_nxt.to = 1'b0;
			s_nxt.pd = 1'b1;
		end
		if (!ext_reset_pin_n) begin
			s_nxt.core.reset = 1'b1;
		end
		if (s_nxt.core.reset) begin
			s_nxt.st = WSW_RUN;
			s_nxt.wdtctl = WDTCTL_RST;
			s_nxt.option = OPTION_RST;
			s_nxt.global_irq_enable = 1'b0;
			s_nxt.irq_en = 8'h00;
			s_nxt.irq_flag = 8'h00;
			s_nxt.core.wake = 1'b0;
			s_nxt.core.vector = 1'b0;
			s_nxt.core.prefetch = 1'b0;
			s_nxt.core.osc_off = 1'b0;
			s_nxt.core.io_hold = 1'b0;
			s_nxt.core.asleep = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.st <= WSW_RUN;
			s_r.wdtctl <= WDTCTL_RST;
			s_r.option <= OPTION_RST;
			s_r.pd <= 1'b1;
			s_r.to <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign core = s_r.core;
	assign vector_addr = s_r.vaddr;

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sleep_nop_a: assert property (
		s_r.st == WSW_RUN && cmd_sleep && pending && ext_reset_pin_n && !tmo
		|=> s_r.st == WSW_RUN && s_r.pd == $past(s_r.pd) && !core.prefetch)
		else $error("sleep with pending interrupt did not act as no-op");
	sleep_entry_a: assert property (
		s_r.st == WSW_RUN && cmd_sleep && !pending && ext_reset_pin_n && !tmo
		|=> !s_r.pd && s_r.to && core.osc_off && core.io_hold && core.prefetch)
		else $error("sleep entry did not update flags and outputs");
	wdt_reset_a: assert property (
		s_r.st == WSW_RUN && tmo |=> core.reset && !s_r.to && s_r.wdtctl == WDTCTL_RST)
		else $error("awake watchdog overflow did not reset");
	wdt_wake_a: assert property (
		s_r.st == WSW_SLEEP && tmo && ext_reset_pin_n ##1 ext_reset_pin_n
		|-> !s_r.to ##1 core.wake && !core.reset)
		else $error("asleep overflow did not wake with expiry flag cleared");
	irq_wake_a: assert property (
		s_r.st == WSW_SLEEP && pending && ext_reset_pin_n ##1 ext_reset_pin_n
		|=> core.wake && !core.asleep)
		else $error("enabled flagged interrupt did not wake");
	vector_jump_a: assert property (
		s_r.st == WSW_WAKE && s_r.global_irq_enable && pending && ext_reset_pin_n
		|=> core.vector && vector_addr == IRQ_VECTOR && !s_r.global_irq_enable)
		else $error("wake with global enable did not vector");
	pin_reset_a: assert property (
		!ext_reset_pin_n |=> core.reset && s_r.st == WSW_RUN && !core.wake)
		else $error("reset pin did not reset device");
	return_gie_a: assert property (
		cmd_return && s_r.st != WSW_WAKE && ext_reset_pin_n && !tmo |=> s_r.global_irq_enable)
		else $error("return did not set global enable");
	flag_set_a: assert property (
		s_r.st == WSW_RUN && irq_event[0] && ext_reset_pin_n && !tmo |=> s_r.irq_flag[0])
		else $error("interrupt flag not set by event");
	prefetch_once_a: assert property (
		core.prefetch && ext_reset_pin_n |=> !core.prefetch && core.asleep)
		else $error("prefetch not a single pulse into sleep");

	// ********************
	// watchdog clearing
	// ********************
	off_clear_a: assert property (
		!wdt_on |=> !tmo)
		else $error("disabled watchdog produced a time-out");
	clear_op_a: assert property (
		cmd_clear |=> !tmo)
		else $error("clear operation did not restart the count");
	osc_fail_a: assert property (
		osc_fail |=> !tmo)
		else $error("oscillator failure did not clear the count");
	xtal_hold_a: assert property (
		crystal_startup_busy && xtal |=> !tmo)
		else $error("count ran while crystal start-up timer busy");
	wake_clear_a: assert property (
		s_r.st == WSW_WAKE |=> !tmo)
		else $error("count not cleared on wake-up");
	pend_clear_a: assert property (
		s_r.st == WSW_SLEEP && pending |=> !tmo)
		else $error("count not cleared on interrupt wake");

	// ********************
	// sleep and wake
	// ********************
	asleep_hold_a: assert property (
		s_r.st == WSW_SLEEP
		|-> core.osc_off && core.io_hold && core.asleep && !s_r.pd)
		else $error("sleep outputs or power-down flag wrong");
	run_awake_a: assert property (
		s_r.st == WSW_RUN |-> !core.asleep && !core.osc_off && !core.io_hold)
		else $error("sleep outputs left on while running");
	late_irq_a: assert property (
		s_r.st == WSW_SLEEP && pending && !tmo && ext_reset_pin_n
		|=> s_r.st == WSW_WAKE && s_r.to && !s_r.pd)
		else $error("interrupt during sleep did not complete then wake");
	sleep_mask_a: assert property (
		s_r.st == WSW_SLEEP && ext_reset_pin_n && !wr
		|=> (s_r.irq_flag & ~WAKE_SRC) == ($past(s_r.irq_flag) & ~WAKE_SRC))
		else $error("unclocked source flagged during sleep");
	wake_resume_a: assert property (
		core.wake |-> !core.reset && !core.asleep && s_r.st == WSW_RUN)
		else $error("wake pulse without resumed execution");
	wake_once_a: assert property (
		core.wake |=> !core.wake)
		else $error("wake pulse longer than one cycle");
	no_vector_a: assert property (
		s_r.st == WSW_WAKE && !s_r.global_irq_enable && ext_reset_pin_n |=> core.wake && !core.vector)
		else $error("wake without global enable jumped to vector");
	vector_gate_a: assert property (
		core.vector |-> core.wake && vector_addr == IRQ_VECTOR && !s_r.global_irq_enable)
		else $error("vector jump without wake or vector address");
	to_hold_a: assert property (
		s_r.st == WSW_SLEEP && !tmo && ext_reset_pin_n |=> $stable(s_r.to))
		else $error("expiry flag changed during sleep without overflow");
	pd_keep_a: assert property (
		s_r.pd && !(s_r.st == WSW_RUN && cmd_sleep && !pending) |=> s_r.pd)
		else $error("power-down flag cleared without sleep entry");
	prefetch_entry_a: assert property (
		core.prefetch |-> s_r.st == WSW_SLEEP && !s_r.pd)
		else $error("prefetch outside sleep entry");
	nop_keep_a: assert property (
		s_r.st == WSW_RUN && cmd_sleep && pending && ext_reset_pin_n && !tmo
		|=> $stable(s_r.to) && !core.asleep && !core.osc_off)
		else $error("no-op sleep changed expiry flag or outputs");

	// ********************
	// device reset and register bus
	// ********************
	ctl_reload_a: assert property (
		core.reset |-> s_r.wdtctl == WDTCTL_RST && s_r.option == OPTION_RST
		&& !s_r.global_irq_enable && s_r.irq_en == 8'h00)
		else $error("device reset did not reload control registers");
	reset_idle_a: assert property (
		core.reset |-> !core.wake && !core.asleep && s_r.st == WSW_RUN)
		else $error("device reset left sleep state active");
	reset_once_a: assert property (
		core.reset && ext_reset_pin_n |=> !core.reset)
		else $error("device reset longer than one cycle");
	flag_race_a: assert property (
		wr && paddr == OFS_IRQ_FLAG && irq_event[0] && s_r.st == WSW_RUN
		&& ext_reset_pin_n && !tmo |=> s_r.irq_flag[0])
		else $error("flag clear won over a new event");
	flag_clear_a: assert property (
		wr && paddr == OFS_IRQ_FLAG && pwdata[0] && !irq_event[0] && s_r.st == WSW_RUN
		|=> !s_r.irq_flag[0])
		else $error("write one did not clear interrupt flag");
	err_zero_a: assert property (
		pslverr |-> pready && prdata == 32'h00000000)
		else $error("error answer without ready or with data");
	ready_once_a: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	sleep_enter_c: cover property (s_r.st == WSW_RUN ##1 s_r.st == WSW_SLEEP);
	irq_wake_c: cover property (s_r.st == WSW_SLEEP && pending && !tmo);
	wdt_wake_c: cover property (s_r.st == WSW_SLEEP && tmo);
	wdt_reset_c: cover property (s_r.st == WSW_RUN && tmo);
	vector_c: cover property (core.vector && vector_addr == IRQ_VECTOR);
endmodule

// *** wsw_pkg.sv ***
// Notes on behaviour
// - watchdog ticks from 31 kHz slow oscillator
// - 16-bit prescaler ratio set by period select
// - shared 8-bit prescaler, owner and rate select
// - time-out reachable from 1 ms to 268 s
// - every reset loads control with 0x08
// - held cleared while crystal start-up timer runs
// - fuse enable forces watchdog on, soft ignored
// - fuse clear: soft enable bit turns on/off
// - period codes 32..65536, 1100-1111 reserved
// - cleared when disabled, clear op, oscillator fail
// - crystal mode wake keeps watchdog cleared until start-up
// - sleep clears count and power-down, sets expiry, osc off, pins held
// - watchdog reset never drives reset pin
// - pin wakes with reset; others resume execution
// - power-down set at power-up; expiry cleared by watchdog
// - only sleep-clocked sources may wake device
// - sleep prefetches next instruction
// - wake needs source enable; global enable picks vector
// - enabled and flagged source wakes immediately
// - pending interrupt turns sleep into no-operation
// - late interrupt: sleep completes, then wakes
// - watchdog cleared on every wake-up
// - servicing clears global enable; return sets it
// - flags set regardless of enables
package wsw_pkg;
	// ********************
	// timing
	// ********************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SLOW_HZ = 31_000;
	localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int unsigned TMO_MIN_MS = 1;
	localparam int unsigned TMO_MAX_S = 268;
	// ********************
	// register map and fields
	// ********************
	localparam logic [7:0] OFS_WDTCTL = 8'h00;
	localparam logic [7:0] OFS_OPTION = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
	localparam logic [4:0] WDTCTL_RST = 5'h08;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam int unsigned OPT_OWNER_BIT = 3;
	localparam int unsigned CFG_FUSE_BIT = 3;
	localparam logic [2:0] FOSC_FIRST_NON_XTAL = 3'h3;
	localparam int unsigned CMD_CLEAR_BIT = 0;
	localparam int unsigned CMD_SLEEP_BIT = 1;
	localparam int unsigned CMD_RETURN_BIT = 2;
	localparam int unsigned ST_GIE_BIT = 2;
	localparam logic [3:0] PERIOD_MAX = 4'hB;
	localparam logic [16:0] PRE_BASE = 17'h00020;
	localparam logic [15:0] IRQ_VECTOR = 16'h0004;
	// ********************
	// types
	// ********************
	typedef enum logic [2:0] {
		WSW_RUN = 3'h1,
		WSW_SLEEP = 3'h2,
		WSW_WAKE = 3'h4
	} wsw_state_t;
	typedef struct packed {
		logic [15:0] pre;
		logic [7:0] post;
		logic tmo;
	} wsw_pre_t;
	typedef struct packed {
		logic reset;
		logic wake;
		logic vector;
		logic osc_off;
		logic io_hold;
		logic prefetch;
		logic asleep;
	} wsw_core_t;
endpackage

// *** wsw_prescaler.sv ***
module wsw_prescaler import wsw_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic clr,
	input wire logic [3:0] period_sel,
	input wire logic use_post,
	input wire logic [2:0] post_rate,
	output logic tmo
);
	wsw_pre_t s_r, s_nxt;
	logic [3:0] sel;
	logic [16:0] lim;
	logic [7:0] plim;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tmo = 1'b0;
		// reserved codes run as the longest ratio rather than stopping
		sel = (period_sel > PERIOD_MAX) ? PERIOD_MAX : period_sel;
		lim = (PRE_BASE << sel) - 17'h00001;
		plim = (8'h01 << post_rate) - 8'h01;
		if (clr) begin
			s_nxt.pre = 16'h0000;
			s_nxt.post = 8'h00;
		end else if (tick) begin
			if (s_r.pre == lim[15:0]) begin
				s_nxt.pre = 16'h0000;
				if (!use_post || s_r.post == plim) begin
					s_nxt.post = 8'h00;
					s_nxt.tmo = 1'b1;
				end else begin
					s_nxt.post = s_r.post + 8'h01;
				end
			end else begin
				s_nxt.pre = s_r.pre + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tmo = s_r.tmo;
endmodule

// *** wsw_cpu.sv ***
// ********************
// processor core model: issues register, clear and sleep operations
// ********************
module wsw_cpu (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// idle cycle after each transfer so psel is never set twice in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output bit ok);
		int n;
		ok = 1'b0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge pclk);
			ok = (pready === 1'b1);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
endmodule

// *** testbench.sv ***
module testbench import wsw_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic ext_reset_pin_n, crystal_startup_busy, osc_fail;
	logic [7:0] paddr, config_word, irq_event, m;
	logic [31:0] pwdata, prdata, v;
	logic [15:0] vector_addr;
	logic [33:0] q[$];
	logic [33:0] e;
	wsw_core_t core;
	int bad_count, tests_run, wakes, resets, seed, vectors, fetches;
	wsw_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .config_word(config_word), .ext_reset_pin_n(ext_reset_pin_n),
		.crystal_startup_busy(crystal_startup_busy), .osc_fail(osc_fail),
		.irq_event(irq_event), .core(core), .vector_addr(vector_addr));
	wsw_cpu cpu (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	always #5 pclk = ~pclk;
	// ********************
	// checking
	// ********************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// monitor pops one note per answered transfer
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
			if (e[33]) check("prdata", prdata, e[31:0]);
		end
		if (core.reset === 1'b1) resets++;
		if (core.wake === 1'b1) wakes++;
		if (core.vector === 1'b1) vectors++;
		if (core.prefetch === 1'b1) fetches++;
	end
	// ********************
	// stimulus
	// ********************
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] x);
		bit ok;
		q.push_back(x);
		cpu.xfer(w, a, d, ok);
		if (!ok) begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0, {2'b10, x});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 34'h0);
	endtask
	task automatic pulse(input logic [7:0] p);
		irq_event <= p;
		@(posedge pclk);
		irq_event <= 8'h00;
		@(posedge pclk);
	endtask
	task automatic wait_wake();
		int n;
		int w0;
		w0 = wakes;
		for (n = 0; n < 40 && wakes == w0; n++) @(posedge pclk);
		if (wakes == w0) begin
			bad_count++;
			conclude();
		end
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		seed = 23;
		config_word = 8'h03;
		ext_reset_pin_n = 1'b1;
		crystal_startup_busy = 1'b0;
		osc_fail = 1'b0;
		irq_event = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_WDTCTL, {27'h0, WDTCTL_RST});
		rd(OFS_OPTION, 32'h000000FF);
		rd(OFS_STATUS, 32'h3);
		wr(OFS_CONFIG, 32'h0);
		rd(OFS_CONFIG, 32'h3);
		bus(1'b0, 8'h40, 32'h0, {2'b11, 32'h0});
		bus(1'b1, 8'h44, 32'h5, {2'b01, 32'h0});
		v = $random(seed);
		v = {27'h0, 4'($unsigned(v) % 12), 1'b1};
		wr(OFS_WDTCTL, v);
		rd(OFS_WDTCTL, v);
		m = 8'(1 << ($unsigned($random(seed)) % 7));
		pulse(m);
		rd(OFS_IRQ_FLAG, {24'h0, m});
		wr(OFS_IRQ_EN, {24'h0, m});
		wr(OFS_CMD, 32'h2);
		rd(OFS_STATUS, 32'h3);
		wr(OFS_IRQ_FLAG, {24'h0, m});
		wr(OFS_CMD, 32'h1);
		wr(OFS_CMD, 32'h2);
		rd(OFS_STATUS, 32'hA);
		check("sleep_hold", {29'h0, core.osc_off, core.io_hold, core.asleep}, 32'h7);
		// source outside the sleep-clocked set must not flag or wake
		wr(OFS_IRQ_EN, {24'h0, m | 8'h80});
		pulse(8'h80);
		repeat (4) @(posedge pclk);
		rd(OFS_STATUS, 32'hA);
		pulse(m);
		wait_wake();
		rd(OFS_STATUS, 32'h2);
		rd(OFS_IRQ_FLAG, {24'h0, m});
		check("vector_addr", {16'h0, vector_addr}, 32'h0);
		wr(OFS_IRQ_FLAG, {24'h0, m});
		wr(OFS_STATUS, 32'h4);
		wr(OFS_CMD, 32'h2);
		pulse(m);
		wait_wake();
		check("vector_addr", {16'h0, vector_addr}, {16'h0, IRQ_VECTOR});
		rd(OFS_STATUS, 32'h2);
		wr(OFS_CMD, 32'h4);
		rd(OFS_STATUS, 32'h6);
		check("resets", resets, 32'h0);
		check("vectors", vectors, 32'h1);
		check("prefetches", fetches, 32'h2);
		// pin reset in mid-run reloads control, clears the interrupt flags and keeps power-down and expiry
		ext_reset_pin_n <= 1'b0;
		@(posedge pclk);
		ext_reset_pin_n <= 1'b1;
		repeat (2) @(posedge pclk);
		check("resets", resets, 32'h1);
		rd(OFS_WDTCTL, {27'h0, WDTCTL_RST});
		rd(OFS_STATUS, 32'h2);
		rd(OFS_IRQ_FLAG, 32'h0);
		conclude();
	end
endmodule
